// file: hw/dpc_drive_powerdown_config.sv
// Drive strength and power-down configuration register with power state control.
// Notes on behaviour
// - bit set: deep powerdown after reset
// - bit clear: standby after reset
// - select code maps to output impedance
// - factory default select gives 45 ohm
// - wake pulse or hardware reset exits
// - software reset always lands in standby
// - hibernate exit also honours the bit
`timescale 1ns/1ps
`default_nettype none
`include "dpc_cfg.svh"
module dpc_drive_powerdown_config (
    // System clock, reset and enable.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Serial link pins.
    input wire logic sck,
    input wire logic csN,
    input wire logic si,
    output logic so,
    output logic soOe,
    // Reset and mode sources.
    input wire logic hwResetN,
    input wire logic jedecResetReq,
    input wire logic softResetReq,
    input wire logic hibernateExitReq,
    // Status.
    output dpc_pkg::dpc_drive_t driveSel,
    output dpc_pkg::dpc_ohms_t impedanceOhms,
    output dpc_pkg::dpc_reg_t volatileValue,
    output logic deepPowerdown,
    output logic standby
);
    import dpc_pkg::*;

    dpc_link_if lnk();
    logic [`DPC_SYNC_W-1:0] syncIn;
    logic [`DPC_SYNC_W-1:0] syncOut;
    logic csSync;
    logic hwRstNSync;
    logic wrValidSync;
    logic wrNvSync;
    dpc_reg_t wrDataSync;
    logic csPrev_q;
    logic csRise;
    logic csIdle;
    logic hwEvent;
    logic noEvt;
    dpc_reg_t nv_q;
    dpc_reg_t vol_q;
    dpc_state_t state_q;
    logic useBit_q;
    dpc_cnt_t wakeCnt_q;
    dpc_cnt_t exitCnt_q;

    // Impedance lookup for the select code.
    function automatic dpc_ohms_t ohmsFor(input dpc_drive_t sel);
        dpc_ohms_t z;
        case (sel)
            3'h1: z = `DPC_Z120;
            3'h2: z = `DPC_Z90;
            3'h3: z = `DPC_Z60;
            3'h5: z = `DPC_Z30;
            3'h6, 3'h7: z = `DPC_Z20;
            default: z = `DPC_Z45;
        endcase
        return z;
    endfunction

    dpc_spi_link uLink (
        .sck(sck),
        .csN(csN),
        .si(si),
        .so(so),
        .soOe(soOe),
        .rst(rst),
        .lnk(lnk.link)
    );

    // Pins and link words cross here; write data is stable well before chip select rises.
    assign syncIn = {csN, hwResetN, lnk.wrValid, lnk.wrNv, lnk.wrData};

    dpc_sync2 #(
        .W(`DPC_SYNC_W),
        .RST(`DPC_SYNC_RST)
    ) uSync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d(syncIn),
        .q(syncOut)
    );

    assign csSync = syncOut[11];
    assign hwRstNSync = syncOut[10];
    assign wrValidSync = syncOut[9];
    assign wrNvSync = syncOut[8];
    assign wrDataSync = syncOut[7:0];
    assign csRise = csSync & ~csPrev_q;
    assign csIdle = csSync & csPrev_q;
    assign hwEvent = ~hwRstNSync | jedecResetReq;
    assign noEvt = ~hwEvent & ~softResetReq & ~hibernateExitReq;

    // Chip select history for edge and idle detection.
    always_ff @(posedge clk) begin
        if (rst) begin
            csPrev_q <= 1'b0;
        end else if (ce) begin
            csPrev_q <= csSync;
        end
    end

    // Register copies; a hardware reset reloads the volatile copy from the stored one.
    // Reserved bits are stored as written, so reads return what the host wrote.
    always_ff @(posedge clk) begin
        if (rst) begin
            nv_q <= `DPC_FACTORY_DEFAULT;
            vol_q <= `DPC_FACTORY_DEFAULT;
        end else if (ce) begin
            if (hwEvent) begin
                vol_q <= nv_q;
            end else if (csRise && wrValidSync) begin
                if (wrNvSync) begin
                    nv_q <= wrDataSync;
                end else begin
                    vol_q <= wrDataSync;
                end
            end
        end
    end

    // Power state; hardware reset outranks software reset, which outranks hibernate exit.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_DECIDE;
            useBit_q <= 1'b1;
        end else if (ce) begin
            if (hwEvent) begin
                state_q <= ST_HOLD;
                useBit_q <= 1'b1;
            end else if (softResetReq) begin
                state_q <= ST_DECIDE;
                useBit_q <= 1'b0;
            end else if (hibernateExitReq) begin
                state_q <= ST_DECIDE;
                useBit_q <= 1'b1;
            end else begin
                case (state_q)
                    ST_HOLD: begin
                        state_q <= ST_DECIDE;
                    end
                    ST_DECIDE: begin
                        if (csSync) begin
                            state_q <= (useBit_q && vol_q[`DPC_PD_BIT]) ? ST_DPD : ST_STANDBY;
                        end
                    end
                    ST_DPD: begin
                        if (csRise && wakeCnt_q >= 16'(`DPC_WAKE_CYC)) begin
                            state_q <= ST_EXIT;
                        end
                    end
                    ST_EXIT: begin
                        if (exitCnt_q == 16'(`DPC_EXIT_CYC - 1)) begin
                            state_q <= ST_STANDBY;
                        end
                    end
                    default: begin
                        state_q <= ST_STANDBY;
                    end
                endcase
            end
        end
    end

    // Wake pulse width, measured on chip select alone while asleep.
    // chip select only
    always_ff @(posedge clk) begin
        if (rst) begin
            wakeCnt_q <= `DPC_CNT_ZERO;
        end else if (ce) begin
            if (csSync || state_q != ST_DPD) begin
                wakeCnt_q <= `DPC_CNT_ZERO;
            end else if (wakeCnt_q != 16'hffff) begin
                wakeCnt_q <= wakeCnt_q + `DPC_CNT_ONE;
            end
        end
    end

    // Exit time counter.
    // exit time
    always_ff @(posedge clk) begin
        if (rst) begin
            exitCnt_q <= `DPC_CNT_ZERO;
        end else if (ce) begin
            if (state_q != ST_EXIT) begin
                exitCnt_q <= `DPC_CNT_ZERO;
            end else begin
                exitCnt_q <= exitCnt_q + `DPC_CNT_ONE;
            end
        end
    end

    // Snapshot for the link; only refreshed while deselected, so a frame never sees it move.
    always_ff @(posedge clk) begin
        if (rst) begin
            lnk.snapVol <= `DPC_FACTORY_DEFAULT;
            lnk.snapNv <= `DPC_FACTORY_DEFAULT;
            lnk.snapAwake <= 1'b0;
        end else if (ce && csIdle) begin
            lnk.snapVol <= vol_q;
            lnk.snapNv <= nv_q;
            lnk.snapAwake <= (state_q == ST_STANDBY);
        end
    end

    // Status outputs, all registered.
    // impedance decode
    always_ff @(posedge clk) begin
        if (rst) begin
            driveSel <= 3'h0;
            impedanceOhms <= `DPC_Z45;
            volatileValue <= `DPC_FACTORY_DEFAULT;
            deepPowerdown <= 1'b0;
            standby <= 1'b0;
        end else if (ce) begin
            driveSel <= vol_q[`DPC_DRV_HI:`DPC_DRV_LO];
            impedanceOhms <= ohmsFor(vol_q[`DPC_DRV_HI:`DPC_DRV_LO]);
            volatileValue <= vol_q;
            deepPowerdown <= (state_q == ST_DPD);
            standby <= (state_q == ST_STANDBY);
        end
    end

    // Checks on the power state and register behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence sDecideHigh;
        state_q == ST_DECIDE && csSync && ce && noEvt;
    endsequence

    sequence sSoft;
        softResetReq && ce && !hwEvent;
    endsequence

    sequence sWakeEdge;
        state_q == ST_DPD && csRise && ce && noEvt;
    endsequence

    AST_DECIDE_DPD: assert property (sDecideHigh ##0 (useBit_q && vol_q[`DPC_PD_BIT]) |=> state_q == ST_DPD ##1 (deepPowerdown || !ce))
        else $error("Reset completion with bit set did not enter deep powerdown.");
    AST_DECIDE_SBY: assert property (sDecideHigh ##0 !(useBit_q && vol_q[`DPC_PD_BIT]) |=> state_q == ST_STANDBY)
        else $error("Reset completion with bit clear did not enter standby.");
    AST_OHMS_45: assert property ((driveSel == 3'h0 || driveSel == 3'h4) |-> impedanceOhms == `DPC_Z45)
        else $error("Select code for 45 ohm shows wrong impedance.");
    AST_OHMS_120: assert property (driveSel == 3'h1 |-> impedanceOhms == `DPC_Z120)
        else $error("Select code for 120 ohm shows wrong impedance.");
    AST_FACTORY: assert property ($past(rst) |-> nv_q == `DPC_FACTORY_DEFAULT && vol_q == `DPC_FACTORY_DEFAULT)
        else $error("Register did not come out of reset at the factory value.");
    AST_WAKE: assert property (sWakeEdge ##0 (wakeCnt_q >= 16'(`DPC_WAKE_CYC)) |=> state_q == ST_EXIT)
        else $error("Wide chip select pulse did not start the exit.");
    AST_NO_EARLY_WAKE: assert property (sWakeEdge ##0 (wakeCnt_q < 16'(`DPC_WAKE_CYC)) |=> state_q == ST_DPD)
        else $error("Narrow chip select pulse woke the device.");
    AST_EXIT_LEN: assert property (state_q == ST_STANDBY && $past(state_q) == ST_EXIT |-> $past(exitCnt_q) == 16'(`DPC_EXIT_CYC - 1))
        else $error("Exit from deep powerdown took the wrong time.");
    AST_SOFT: assert property (sSoft |=> state_q == ST_DECIDE && !useBit_q)
        else $error("Software reset did not ignore the powerdown bit.");
    AST_HIB: assert property (hibernateExitReq && ce && !hwEvent && !softResetReq |=> state_q == ST_DECIDE && useBit_q)
        else $error("Hibernate exit did not consult the powerdown bit.");
    AST_WRITE_VOL: assert property (csRise && wrValidSync && !wrNvSync && ce && !hwEvent |=> vol_q == $past(wrDataSync))
        else $error("Volatile write was not stored.");
    AST_DEFER: assert property (state_q == ST_DECIDE && !csSync && ce && noEvt |=> state_q == ST_DECIDE)
        else $error("Power decision taken while chip select was low.");
endmodule
`default_nettype wire

// file: hw/dpc_cfg.svh
// Constants for the drive strength and power-down configuration block.
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH

// Register layout and factory value.
`define DPC_FACTORY_DEFAULT 8'h08
`define DPC_DRV_HI 7
`define DPC_DRV_LO 5
`define DPC_PD_BIT 2

// Command opcodes and register addresses on the serial link.
`define DPC_OP_WRITE_ANY 8'h71
`define DPC_OP_READ_ANY 8'h65
`define DPC_OP_READ_DRV 8'h45
`define DPC_ADDR_VOL 24'h070005
`define DPC_ADDR_NV 24'h000005

// Frame bit positions, counted from zero on the serial clock.
`define DPC_OP_LAST_BIT 6'h07
`define DPC_ADDR_LAST_BIT 6'h1f
`define DPC_DATA_LAST_BIT 6'h27
`define DPC_BIT_CNT_MAX 6'h3f
`define DPC_OUT_PTR_TOP 3'h7

// Synchroniser reset pattern: chip select low, reset pin released.
`define DPC_SYNC_W 12
`define DPC_SYNC_RST 12'h400

// Timing: wake pulse is a least time, exit time a longest time.
`define DPC_CLK_MHZ 100
`define DPC_CS_WAKE_NS 50
`define DPC_EXIT_NS 3000
`define DPC_WAKE_CYC ((`DPC_CS_WAKE_NS * `DPC_CLK_MHZ + 999) / 1000)
`define DPC_EXIT_CYC ((`DPC_EXIT_NS * `DPC_CLK_MHZ) / 1000)
`define DPC_CNT_ZERO 16'h0000
`define DPC_CNT_ONE 16'h0001

// Typical output impedance in ohms for each select code.
`define DPC_Z20 7'h14
`define DPC_Z30 7'h1e
`define DPC_Z45 7'h2d
`define DPC_Z60 7'h3c
`define DPC_Z90 7'h5a
`define DPC_Z120 7'h78

`endif

// file: hw/dpc_pkg.sv
// Types shared by the drive strength and power-down configuration block.
package dpc_pkg;
    typedef logic [7:0] dpc_reg_t;
    typedef logic [2:0] dpc_drive_t;
    typedef logic [6:0] dpc_ohms_t;
    typedef logic [15:0] dpc_cnt_t;
    typedef enum logic [2:0] {ST_HOLD, ST_DECIDE, ST_STANDBY, ST_DPD, ST_EXIT} dpc_state_t;
endpackage

// file: hw/dpc_link_if.sv
// Carrier between the serial link logic and the register core.
`timescale 1ns/1ps
`default_nettype none
interface dpc_link_if;
    // Written by the link, held stable after the frame ends.
    logic wrValid;
    logic wrNv;
    dpc_pkg::dpc_reg_t wrData;
    // Written by the core, only changed while chip select is idle.
    dpc_pkg::dpc_reg_t snapVol;
    dpc_pkg::dpc_reg_t snapNv;
    logic snapAwake;

    modport link (output wrValid, output wrNv, output wrData, input snapVol, input snapNv, input snapAwake);
    modport core (input wrValid, input wrNv, input wrData, output snapVol, output snapNv, output snapAwake);
endinterface
`default_nettype wire

// file: hw/dpc_sync2.sv
// Two flip-flop synchroniser, one pair per bit.
`timescale 1ns/1ps
`default_nettype none
module dpc_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Asynchronous data in, synchronised data out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : gBit
            logic meta_q;
            // The first stage is read only by the second stage.
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta_q <= RST[i];
                    q[i] <= RST[i];
                end else if (ce) begin
                    meta_q <= d[i];
                    q[i] <= meta_q;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// file: hw/dpc_spi_link.sv
// Serial link front end on the host's serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_cfg.svh"
module dpc_spi_link (
    // Link pins.
    input wire logic sck,
    input wire logic csN,
    input wire logic si,
    output logic so,
    output logic soOe,
    // System reset, used only to clear the pending write.
    input wire logic rst,
    // Carrier to the register core.
    dpc_link_if.link lnk
);
    import dpc_pkg::*;

    logic [5:0] bitCnt_q;
    logic [7:0] opcode_q;
    logic [23:0] addr_q;
    logic [7:0] dataSh_q;
    dpc_reg_t rdData_q;
    logic rdActive_q;
    logic [2:0] outPtr_q;
    logic awakeMeta_q;
    logic awake_q;
    logic [7:0] opNow;
    logic [23:0] addrNow;
    logic [7:0] dataNow;

    assign opNow = {opcode_q[6:0], si};
    assign addrNow = {addr_q[22:0], si};
    assign dataNow = {dataSh_q[6:0], si};

    // The core's awake level passes two flops; it settles long before the opcode ends.
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            awakeMeta_q <= 1'b0;
            awake_q <= 1'b0;
        end else begin
            awakeMeta_q <= lnk.snapAwake;
            awake_q <= awakeMeta_q;
        end
    end

    // Bit counter and input shifters, cleared by the frame's own chip select.
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            bitCnt_q <= 6'h00;
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
            dataSh_q <= 8'h00;
        end else begin
            if (bitCnt_q != `DPC_BIT_CNT_MAX) begin
                bitCnt_q <= bitCnt_q + 6'h01;
            end
            if (bitCnt_q <= `DPC_OP_LAST_BIT) begin
                opcode_q <= opNow;
            end else if (bitCnt_q <= `DPC_ADDR_LAST_BIT) begin
                addr_q <= addrNow;
            end else begin
                dataSh_q <= dataNow;
            end
        end
    end

    // Read data load; a sleeping device ignores clock and data, and its chip select acts only as a wake pulse.
    // clock and data ignored
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            rdData_q <= 8'h00;
            rdActive_q <= 1'b0;
        end else if (awake_q && bitCnt_q == `DPC_OP_LAST_BIT && opNow == `DPC_OP_READ_DRV) begin
            rdData_q <= lnk.snapVol;
            rdActive_q <= 1'b1;
        end else if (awake_q && bitCnt_q == `DPC_ADDR_LAST_BIT && opcode_q == `DPC_OP_READ_ANY) begin
            rdActive_q <= 1'b1;
            if (addrNow == `DPC_ADDR_VOL) begin
                rdData_q <= lnk.snapVol;
            end else if (addrNow == `DPC_ADDR_NV) begin
                rdData_q <= lnk.snapNv;
            end else begin
                rdData_q <= 8'h00;
            end
        end
    end

    // Output shifts on the falling edge; the byte repeats if the host keeps clocking.
    always_ff @(negedge sck or posedge csN) begin
        if (csN) begin
            so <= 1'b0;
            soOe <= 1'b0;
            outPtr_q <= `DPC_OUT_PTR_TOP;
        end else if (rdActive_q) begin
            so <= rdData_q[outPtr_q];
            soOe <= 1'b1;
            outPtr_q <= outPtr_q - 3'h1;
        end
    end

    // Pending write survives the frame end so the core can take it at chip select rise.
    // both register copies
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            lnk.wrValid <= 1'b0;
            lnk.wrNv <= 1'b0;
            lnk.wrData <= 8'h00;
        end else if (bitCnt_q == 6'h00) begin
            lnk.wrValid <= 1'b0;
        end else if (awake_q && bitCnt_q == `DPC_DATA_LAST_BIT && opcode_q == `DPC_OP_WRITE_ANY
                     && (addr_q == `DPC_ADDR_VOL || addr_q == `DPC_ADDR_NV)) begin
            lnk.wrValid <= 1'b1;
            lnk.wrNv <= (addr_q == `DPC_ADDR_NV);
            lnk.wrData <= dataNow;
        end
    end
endmodule
`default_nettype wire

// file: verif/dpc_spi_host.sv
// Serial host model that frames register commands on the link.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_cfg.svh"
module dpc_spi_host (
    // Pins driven by the host.
    output logic sck,
    output logic csN,
    output logic si,
    // Pins driven by the device.
    input wire logic so,
    input wire logic soOe
);
    import dpc_pkg::*;

    // Clock parked low between frames; select idle high.
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        si = 1'b0;
    end

    // One mode 0 frame, MSB first; a read bit taken while the driver is off is poisoned.
    task automatic xfer(input logic [39:0] bits, input int nbits, input int rdFirst, output dpc_reg_t rd);
        rd = 8'h00;
        #0.7 csN = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            si = bits[39 - i];
            #3 sck = 1'b1;
            if (i >= rdFirst && i < rdFirst + 8) begin
                rd[7 - (i - rdFirst)] = (soOe === 1'b1) ? so : 1'bx;
            end
            #3 sck = 1'b0;
        end
        #3 csN = 1'b1;
        // The line is inverted, so it no longer shows the last bit.
        si = ~si;
        // Select stays high long enough for the write to commit and the snapshot to refresh.
        #40;
    endtask

    task automatic write(input logic [23:0] addr, input dpc_reg_t data, input int nbits);
        dpc_reg_t junk;
        xfer({`DPC_OP_WRITE_ANY, addr, data | 8'h08}, nbits, 64, junk);
    endtask

    task automatic read(input logic dedicated, input logic [23:0] addr, output dpc_reg_t rd);
        if (dedicated) begin
            xfer({`DPC_OP_READ_DRV, 32'h00000000}, 16, 8, rd);
        end else begin
            xfer({`DPC_OP_READ_ANY, addr, 8'h00}, 40, 32, rd);
        end
    endtask

    task automatic pulse(input int widthNs);
        csN = 1'b0;
        #(widthNs) csN = 1'b1;
    endtask

    // Select held at a level with no clocks, for deferred decisions.
    task automatic setCs(input logic v);
        csN = v;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_drive_and_powerdown_config.sv
// Self-checking bench for the drive strength and power-down configuration block.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_cfg.svh"
module tb_drive_and_powerdown_config;
    import dpc_pkg::*;
    logic clk;
    logic rst;
    logic ce;
    logic hwResetN;
    logic jedecResetReq;
    logic softResetReq;
    logic hibernateExitReq;
    wire logic sck;
    wire logic csN;
    wire logic si;
    wire logic so;
    wire logic soOe;
    dpc_drive_t driveSel;
    dpc_ohms_t impedanceOhms;
    dpc_reg_t volatileValue;
    logic deepPowerdown;
    logic standby;
    int errCount;
    int checksDone;
    int cycles;
    int nvReg;
    int volReg;
    dpc_reg_t rd;
    dpc_reg_t d;
    logic [31:0] r;

    dpc_drive_powerdown_config dpc_drive_powerdown_config_i (.clk(clk), .rst(rst), .ce(ce), .sck(sck),
        .csN(csN), .si(si), .so(so), .soOe(soOe), .hwResetN(hwResetN), .jedecResetReq(jedecResetReq),
        .softResetReq(softResetReq), .hibernateExitReq(hibernateExitReq), .driveSel(driveSel),
        .impedanceOhms(impedanceOhms), .volatileValue(volatileValue), .deepPowerdown(deepPowerdown),
        .standby(standby));

    dpc_spi_host dpc_spi_host_i (.sck(sck), .csN(csN), .si(si), .so(so), .soOe(soOe));

    // System clock, 10 ns.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard: the sequence needs about 2100 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            fail("timeout");
            results();
        end
    end

    task automatic fail(input string msg);
        errCount++;
        $display("ERROR %0t %s", $time, msg);
    endtask

    task automatic cmp8(input dpc_reg_t got, input int exp, input string what);
        checksDone++;
        if (got !== dpc_reg_t'(exp)) begin
            fail($sformatf("%s got %h exp %h", what, got, dpc_reg_t'(exp)));
        end
    endtask

    task automatic cmpBit(input logic got, input logic exp, input string what);
        checksDone++;
        if (got !== exp) begin
            fail($sformatf("%s got %b exp %b", what, got, exp));
        end
    endtask

    // Select code to typical ohms, table kept apart from the design's.
    function automatic dpc_ohms_t expOhms(input int code);
        case (code & 7)
            1: return 7'h78;
            2: return 7'h5a;
            3: return 7'h3c;
            5: return 7'h1e;
            6, 7: return 7'h14;
            default: return 7'h2d;
        endcase
    endfunction

    task automatic cmpDrive();
        checksDone++;
        if (driveSel !== dpc_drive_t'(volReg >> 5) || impedanceOhms !== expOhms(volReg >> 5)) begin
            fail($sformatf("drive %h ohms %h", driveSel, impedanceOhms));
        end
    endtask

    task automatic checkState(input logic deep_powerdown_state, input logic sb);
        cmpBit(deepPowerdown, deep_powerdown_state, "deep powerdown");
        cmpBit(standby, sb, "standby");
    endtask

    // Bounded wait for a power state, then compare.
    task automatic waitState(input logic deep_powerdown_state, input logic sb, input int maxc);
        for (int n = 0; n < maxc && !(deepPowerdown === deep_powerdown_state && standby === sb); n++) begin
            @(negedge clk);
        end
        checkState(deep_powerdown_state, sb);
    endtask

    // Kinds: 0 reset pin, 1 bus reset, 2 software reset, 3 hibernate exit.
    task automatic resetEvent(input int kind);
        @(negedge clk);
        hwResetN = (kind != 0);
        jedecResetReq = (kind == 1);
        softResetReq = (kind == 2);
        hibernateExitReq = (kind == 3);
        repeat ((kind == 0) ? 4 : 1) @(negedge clk);
        hwResetN = 1'b1;
        jedecResetReq = 1'b0;
        softResetReq = 1'b0;
        hibernateExitReq = 1'b0;
        // Pin and bus resets both reload the volatile copy.
        if (kind <= 1) begin
            volReg = nvReg;
        end
    endtask

    // A pulse wide enough to wake; select then stays high before the next frame.
    task automatic wake();
        dpc_spi_host_i.pulse(60);
        waitState(1'b0, 1'b1, 330);
        repeat (5) @(negedge clk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        hwResetN = 1'b1;
        jedecResetReq = 1'b0;
        softResetReq = 1'b0;
        hibernateExitReq = 1'b0;
        errCount = 0;
        checksDone = 0;
        cycles = 0;
        nvReg = 8'h08;
        volReg = 8'h08;
        r = $urandom(32'hce7e);
        repeat (20) @(negedge clk);
        rst = 1'b0;
        waitState(1'b0, 1'b1, 20);
        cmp8(volatileValue, 8'h08, "factory");
        cmpDrive();
        repeat (5) @(negedge clk);
        $display("test reset done");
        // every select code, random reserved bits
        for (int c = 0; c < 8; c++) begin
            r = $urandom();
            d = {c[2:0], r[4:0]};
            dpc_spi_host_i.write(`DPC_ADDR_VOL, d, 40);
            volReg = d | 8'h08;
            repeat (10) @(negedge clk);
            cmp8(volatileValue, volReg, "volatile write");
            cmpDrive();
            cmpBit(soOe, 1'b0, "idle driver");
            dpc_spi_host_i.read(c[0] == 1'b0, `DPC_ADDR_VOL, rd);
            cmp8(rd, volReg, "read back");
            repeat (5) @(negedge clk);
        end
        $display("test select codes done");
        dpc_spi_host_i.write(24'h070006, 8'hf5, 40);
        dpc_spi_host_i.write(`DPC_ADDR_VOL, 8'hff, 36);
        repeat (10) @(negedge clk);
        cmp8(volatileValue, volReg, "refused write");
        dpc_spi_host_i.read(1'b0, 24'h070006, rd);
        cmp8(rd, 8'h00, "unmapped read");
        repeat (5) @(negedge clk);
        dpc_spi_host_i.write(`DPC_ADDR_NV, 8'h0c, 40);
        nvReg = 8'h0c;
        repeat (10) @(negedge clk);
        cmp8(volatileValue, volReg, "volatile kept");
        dpc_spi_host_i.read(1'b0, `DPC_ADDR_NV, rd);
        cmp8(rd, nvReg, "stored read");
        repeat (5) @(negedge clk);
        $display("test access done");
        resetEvent(0);
        waitState(1'b1, 1'b0, 20);
        cmp8(volatileValue, 8'h0c, "reload");
        dpc_spi_host_i.pulse(20);
        repeat (30) @(negedge clk);
        checkState(1'b1, 1'b0);
        wake();
        resetEvent(2);
        repeat (6) @(negedge clk);
        checkState(1'b0, 1'b1);
        resetEvent(3);
        waitState(1'b1, 1'b0, 10);
        wake();
        resetEvent(1);
        waitState(1'b1, 1'b0, 10);
        // a frame while asleep only acts as a wake pulse
        dpc_spi_host_i.write(`DPC_ADDR_VOL, 8'h00, 40);
        waitState(1'b0, 1'b1, 330);
        cmp8(volatileValue, volReg, "asleep write ignored");
        repeat (5) @(negedge clk);
        $display("test power states done");
        dpc_spi_host_i.setCs(1'b0);
        repeat (3) @(negedge clk);
        resetEvent(3);
        repeat (10) @(negedge clk);
        checkState(1'b0, 1'b0);
        dpc_spi_host_i.setCs(1'b1);
        waitState(1'b1, 1'b0, 10);
        wake();
        $display("test deferred decision done");
        // clock enable low freezes the power state
        ce = 1'b0;
        resetEvent(3);
        repeat (5) @(negedge clk);
        checkState(1'b0, 1'b1);
        ce = 1'b1;
        repeat (5) @(negedge clk);
        checkState(1'b0, 1'b1);
        $display("test clock enable done");
        // A second reset restores the factory copy in both places.
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        nvReg = 8'h08;
        volReg = 8'h08;
        waitState(1'b0, 1'b1, 20);
        cmp8(volatileValue, 8'h08, "second reset");
        $display("test second reset done");
        results();
    end
endmodule
`default_nettype wire
